// ===== rtl/spc_div_decode.sv
// decodes stored divider codes into divide ratios with validity flags
// assumes codes come straight from the register slice; purely combinational
`timescale 1ns/1ps
module spc_div_decode
  import spc_pkg::*;
(
  input wire logic [SPC_FBDIV_W-1:0] i_fb_code,
  input wire logic [SPC_FBDIV_W-1:0] i_fb_g3_code,
  input wire logic [SPC_REFDIV_W-1:0] i_ref_code,
  output logic [SPC_RATIO_W-1:0] o_fb_ratio,
  output logic o_fb_ok,
  output logic [SPC_RATIO_W-1:0] o_fb_g3_ratio,
  output logic o_fb_g3_ok,
  output logic [SPC_REFDIV_W-1:0] o_ref_ratio,
  output logic o_ref_ok
);

  // ==========================================================================
  // feedback code to ratio, shared by both feedback fields
  function automatic logic [SPC_RATIO_W-1:0] fb_ratio(input logic [SPC_FBDIV_W-1:0] c);
    fb_ratio = {1'b0, c} + SPC_FB_OFFSET;
  endfunction : fb_ratio

  function automatic logic fb_ok(input logic [SPC_FBDIV_W-1:0] c);
    fb_ok = (c >= SPC_FB_CODE_MIN) && (c <= SPC_FB_CODE_MAX);
  endfunction : fb_ok

  always_comb begin
    o_fb_ratio = fb_ratio(i_fb_code);
    o_fb_ok = fb_ok(i_fb_code);
    o_fb_g3_ratio = fb_ratio(i_fb_g3_code);
    o_fb_g3_ok = fb_ok(i_fb_g3_code);
  end

  // ==========================================================================
  // reference divider code table; unlisted codes report ratio 0
  always_comb begin
    o_ref_ok = 1'b1;
    case (i_ref_code)
      SPC_REF_C_DIV2: o_ref_ratio = 5'd2;
      SPC_REF_C_DIV3: o_ref_ratio = 5'd3;
      SPC_REF_C_DIV4: o_ref_ratio = 5'd4;
      SPC_REF_C_DIV5: o_ref_ratio = 5'd5;
      SPC_REF_C_DIV6: o_ref_ratio = 5'd6;
      SPC_REF_C_DIV8: o_ref_ratio = 5'd8;
      SPC_REF_C_DIV10: o_ref_ratio = 5'd10;
      SPC_REF_C_DIV12: o_ref_ratio = 5'd12;
      SPC_REF_C_DIV16: o_ref_ratio = 5'd16;
      SPC_REF_C_DIV20: o_ref_ratio = 5'd20;
      SPC_REF_C_DIV1: o_ref_ratio = 5'd1;
      default: begin
        o_ref_ratio = 5'd0;
        o_ref_ok = 1'b0;
      end
    endcase
  end

endmodule : spc_div_decode

// ===== rtl/spc_pkg.sv
// constants for the second loop configuration register slice
// assumes 16-bit words reached at word addresses over the reconfiguration port
package spc_pkg;

  // ==========================================================================
  // port widths
  localparam int unsigned SPC_AW = 10;
  localparam int unsigned SPC_DW = 16;

  // ==========================================================================
  // word addresses
  localparam logic [SPC_AW-1:0] SPC_ADDR_FBDIV = 10'h094;
  localparam logic [SPC_AW-1:0] SPC_ADDR_CFG3 = 10'h095;
  localparam logic [SPC_AW-1:0] SPC_ADDR_CP = 10'h096;
  localparam logic [SPC_AW-1:0] SPC_ADDR_REFCLK = 10'h098;
  localparam logic [SPC_AW-1:0] SPC_ADDR_LPF = 10'h099;
  localparam logic [SPC_AW-1:0] SPC_ADDR_CFG1_G3 = 10'h09A;
  localparam logic [SPC_AW-1:0] SPC_ADDR_CFG2_G3 = 10'h09B;
  localparam logic [SPC_AW-1:0] SPC_ADDR_LPF_G3 = 10'h09C;
  localparam logic [SPC_AW-1:0] SPC_ADDR_LOCK_G3 = 10'h09D;
  localparam logic [SPC_AW-1:0] SPC_ADDR_RSVD2 = 10'h09E;
  localparam logic [SPC_AW-1:0] SPC_ADDR_FBDIV_G3 = 10'h09F;

  // ==========================================================================
  // field positions and widths
  localparam int unsigned SPC_FBDIV_LSB = 0;
  localparam int unsigned SPC_FBDIV_G3_LSB = 8;
  localparam int unsigned SPC_FBDIV_W = 8;
  localparam int unsigned SPC_SRC_LSB = 3;
  localparam int unsigned SPC_SRC_W = 3;
  localparam int unsigned SPC_ALT_EN_BIT = 6;
  localparam int unsigned SPC_REFDIV_LSB = 7;
  localparam int unsigned SPC_REFDIV_W = 5;
  localparam int unsigned SPC_CAL_EN_BIT = 12;
  localparam int unsigned SPC_CAL_SEL_BIT = 13;
  localparam int unsigned SPC_CP_W = 10;
  localparam int unsigned SPC_LPF_G3_W = 10;
  localparam int unsigned SPC_RATIO_W = 9;

  // ==========================================================================
  // feedback divider code mapping: code = ratio - offset
  localparam logic [SPC_RATIO_W-1:0] SPC_FB_OFFSET = 9'h002;
  localparam logic [SPC_FBDIV_W-1:0] SPC_FB_CODE_MIN = 8'h0E;
  localparam logic [SPC_FBDIV_W-1:0] SPC_FB_CODE_MAX = 8'h9E;

  // reference divider codes
  localparam logic [SPC_REFDIV_W-1:0] SPC_REF_C_DIV2 = 5'h00;
  localparam logic [SPC_REFDIV_W-1:0] SPC_REF_C_DIV3 = 5'h01;
  localparam logic [SPC_REFDIV_W-1:0] SPC_REF_C_DIV4 = 5'h02;
  localparam logic [SPC_REFDIV_W-1:0] SPC_REF_C_DIV5 = 5'h03;
  localparam logic [SPC_REFDIV_W-1:0] SPC_REF_C_DIV6 = 5'h05;
  localparam logic [SPC_REFDIV_W-1:0] SPC_REF_C_DIV8 = 5'h06;
  localparam logic [SPC_REFDIV_W-1:0] SPC_REF_C_DIV10 = 5'h07;
  localparam logic [SPC_REFDIV_W-1:0] SPC_REF_C_DIV12 = 5'h0D;
  localparam logic [SPC_REFDIV_W-1:0] SPC_REF_C_DIV16 = 5'h0E;
  localparam logic [SPC_REFDIV_W-1:0] SPC_REF_C_DIV20 = 5'h0F;
  localparam logic [SPC_REFDIV_W-1:0] SPC_REF_C_DIV1 = 5'h10;

  // ==========================================================================
  // reset values
  localparam logic [SPC_FBDIV_W-1:0] SPC_RST_FBDIV = 8'h0E;
  localparam logic [SPC_FBDIV_W-1:0] SPC_RST_FBDIV_G3 = 8'h0E;
  localparam logic [SPC_REFDIV_W-1:0] SPC_RST_REFDIV = 5'h10;
  localparam logic [SPC_SRC_W-1:0] SPC_RST_SRC = 3'h0;
  localparam logic [SPC_CP_W-1:0] SPC_RST_CP = 10'h000;
  localparam logic [SPC_LPF_G3_W-1:0] SPC_RST_LPF_G3 = 10'h000;
  localparam logic [SPC_DW-1:0] SPC_RST_WORD = 16'h0000;
  localparam logic SPC_RST_BIT = 1'b0;

endpackage : spc_pkg

// ===== rtl/spc_regs.sv
// register slice for the second loop: feedback, reference, pump and filter words
// assumes a single-cycle port master: enable pulses one cycle, ready answers one later
//
// Functional notes
// R1: feedback divider code in 0x94 bits 7:0, code is divider minus two.
// R2: third-generation feedback divider in 0x9F bits 15:8, same minus-two code.
// R3: reference divider five-bit code in 0x98 bits 11:7, table-encoded.
// R4: reference source select three bits in 0x98 bits 5:3, stored as is.
// R5: alternate reference path enable in 0x98 bit 6.
// R6: calibration enable in 0x98 bit 12.
// R7: calibration select in 0x98 bit 13.
// R8: charge pump ten bits in 0x96 bits 9:0, untranslated.
// R9: loop filter held as full word at 0x99, untranslated.
// R10: third-generation loop filter ten bits in 0x9C bits 9:0.
// R11: full configuration words at 0x95, 0x9A and 0x9B.
// R12: third-generation lock configuration full word at 0x9D.
// R13: reserved attribute full word at 0x9E, readable and writable.
// R14: configuration logic leaves reserved bits and undocumented attributes at defaults.
// R15: writes change only owned field bits; other bits of a word stay untouched.
// R16: reads return most recently written field values in encoded form.
`timescale 1ns/1ps
module spc_regs
  import spc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_cfg_en,
  input wire logic i_cfg_we,
  input wire logic [SPC_AW-1:0] i_cfg_addr,
  input wire logic [SPC_DW-1:0] i_cfg_wdata,
  output logic o_cfg_rdy,
  output logic [SPC_DW-1:0] o_cfg_rdata,
  output logic [SPC_FBDIV_W-1:0] o_second_loop_feedback_divider,
  output logic [SPC_FBDIV_W-1:0] o_second_loop_feedback_divider_gen3,
  output logic [SPC_REFDIV_W-1:0] o_second_loop_refclk_divider,
  output logic [SPC_SRC_W-1:0] o_alt_refclk_source_select,
  output logic o_alt_refclk_path_enable,
  output logic o_calibration_enable,
  output logic o_calibration_select,
  output logic [SPC_CP_W-1:0] o_charge_pump_setting,
  output logic [SPC_DW-1:0] o_loop_filter_setting,
  output logic [SPC_LPF_G3_W-1:0] o_loop_filter_setting_gen3,
  output logic [SPC_DW-1:0] o_config_word_three,
  output logic [SPC_DW-1:0] o_config_word_one_gen3,
  output logic [SPC_DW-1:0] o_config_word_two_gen3,
  output logic [SPC_DW-1:0] o_lock_config_gen3,
  output logic [SPC_DW-1:0] o_reserved_attribute_two,
  output logic [SPC_RATIO_W-1:0] o_fb_ratio,
  output logic o_fb_ratio_ok,
  output logic [SPC_RATIO_W-1:0] o_fb_gen3_ratio,
  output logic o_fb_gen3_ratio_ok,
  output logic [SPC_REFDIV_W-1:0] o_ref_ratio,
  output logic o_ref_ratio_ok
);

  // ==========================================================================
  // state
  typedef enum logic [1:0] {
    SPC_ACC_IDLE = 2'b00,
    SPC_ACC_READ = 2'b01,
    SPC_ACC_WRITE = 2'b10
  } spc_acc_t;

  typedef struct packed {
    spc_acc_t acc;
    logic [SPC_DW-1:0] rdata;
    logic [SPC_FBDIV_W-1:0] fbdiv;
    logic [SPC_FBDIV_W-1:0] fbdiv_g3;
    logic [SPC_REFDIV_W-1:0] refdiv;
    logic [SPC_SRC_W-1:0] src;
    logic alt_en;
    logic cal_en;
    logic cal_sel;
    logic [SPC_CP_W-1:0] cp;
    logic [SPC_DW-1:0] lpf;
    logic [SPC_LPF_G3_W-1:0] lpf_g3;
    logic [SPC_DW-1:0] cfg3;
    logic [SPC_DW-1:0] cfg1_g3;
    logic [SPC_DW-1:0] cfg2_g3;
    logic [SPC_DW-1:0] lock_g3;
    logic [SPC_DW-1:0] rsvd2;
    logic [SPC_RATIO_W-1:0] fb_ratio;
    logic fb_ok;
    logic [SPC_RATIO_W-1:0] fb_g3_ratio;
    logic fb_g3_ok;
    logic [SPC_REFDIV_W-1:0] ref_ratio;
    logic ref_ok;
  } spc_state_t;

  localparam spc_state_t SPC_STATE_RST = '{
    acc: SPC_ACC_IDLE,
    rdata: SPC_RST_WORD,
    fbdiv: SPC_RST_FBDIV,
    fbdiv_g3: SPC_RST_FBDIV_G3,
    refdiv: SPC_RST_REFDIV,
    src: SPC_RST_SRC,
    alt_en: SPC_RST_BIT,
    cal_en: SPC_RST_BIT,
    cal_sel: SPC_RST_BIT,
    cp: SPC_RST_CP,
    lpf: SPC_RST_WORD,
    lpf_g3: SPC_RST_LPF_G3,
    cfg3: SPC_RST_WORD,
    cfg1_g3: SPC_RST_WORD,
    cfg2_g3: SPC_RST_WORD,
    lock_g3: SPC_RST_WORD,
    rsvd2: SPC_RST_WORD,
    fb_ratio: 9'h000,
    fb_ok: 1'b0,
    fb_g3_ratio: 9'h000,
    fb_g3_ok: 1'b0,
    ref_ratio: 5'h00,
    ref_ok: 1'b0
  };

  spc_state_t st_q;
  spc_state_t st_d;

  // ==========================================================================
  // decode of the stored divider codes
  // ratios are registered below, so they lag their codes by one cycle
  logic [SPC_RATIO_W-1:0] dec_fb_ratio;
  logic dec_fb_ok;
  logic [SPC_RATIO_W-1:0] dec_fb_g3_ratio;
  logic dec_fb_g3_ok;
  logic [SPC_REFDIV_W-1:0] dec_ref_ratio;
  logic dec_ref_ok;

  spc_div_decode u_div_decode (
    .i_fb_code(st_q.fbdiv),
    .i_fb_g3_code(st_q.fbdiv_g3),
    .i_ref_code(st_q.refdiv),
    .o_fb_ratio(dec_fb_ratio),
    .o_fb_ok(dec_fb_ok),
    .o_fb_g3_ratio(dec_fb_g3_ratio),
    .o_fb_g3_ok(dec_fb_g3_ok),
    .o_ref_ratio(dec_ref_ratio),
    .o_ref_ok(dec_ref_ok)
  );

  // ==========================================================================
  // address decode, used by both the write and read paths
  function automatic logic hit(input logic [SPC_AW-1:0] a, input logic [SPC_AW-1:0] word);
    hit = (a == word);
  endfunction : hit

  // ==========================================================================
  // readback: fields packed at their word positions, unowned bits read zero
  function automatic logic [SPC_DW-1:0] readback(input spc_state_t s,
                                                 input logic [SPC_AW-1:0] a);
    logic [SPC_DW-1:0] w;
    w = SPC_RST_WORD;
    if (hit(a, SPC_ADDR_FBDIV)) begin
      w[SPC_FBDIV_LSB +: SPC_FBDIV_W] = s.fbdiv; // R1
    end
    if (hit(a, SPC_ADDR_FBDIV_G3)) begin
      w[SPC_FBDIV_G3_LSB +: SPC_FBDIV_W] = s.fbdiv_g3; // R2
    end
    if (hit(a, SPC_ADDR_REFCLK)) begin
      w[SPC_REFDIV_LSB +: SPC_REFDIV_W] = s.refdiv; // R3
      w[SPC_SRC_LSB +: SPC_SRC_W] = s.src; // R4
      w[SPC_ALT_EN_BIT] = s.alt_en; // R5
      w[SPC_CAL_EN_BIT] = s.cal_en; // R6
      w[SPC_CAL_SEL_BIT] = s.cal_sel; // R7
    end
    if (hit(a, SPC_ADDR_CP)) begin
      w[SPC_CP_W-1:0] = s.cp; // R8
    end
    if (hit(a, SPC_ADDR_LPF)) begin
      w = s.lpf; // R9
    end
    if (hit(a, SPC_ADDR_LPF_G3)) begin
      w[SPC_LPF_G3_W-1:0] = s.lpf_g3; // R10
    end
    if (hit(a, SPC_ADDR_CFG3)) begin
      w = s.cfg3; // R11
    end
    if (hit(a, SPC_ADDR_CFG1_G3)) begin
      w = s.cfg1_g3; // R11
    end
    if (hit(a, SPC_ADDR_CFG2_G3)) begin
      w = s.cfg2_g3; // R11
    end
    if (hit(a, SPC_ADDR_LOCK_G3)) begin
      w = s.lock_g3; // R12
    end
    if (hit(a, SPC_ADDR_RSVD2)) begin
      w = s.rsvd2; // R13
    end
    readback = w;
  endfunction : readback

  // ==========================================================================
  // next state
  logic wr;
  logic rd;

  always_comb begin
    wr = i_cfg_en && i_cfg_we;
    rd = i_cfg_en && !i_cfg_we;
    st_d = st_q;
    // the access taken at this edge; it also times the answer strobe
    case ({i_cfg_en, i_cfg_we})
      2'b11: st_d.acc = SPC_ACC_WRITE;
      2'b10: st_d.acc = SPC_ACC_READ;
      default: st_d.acc = SPC_ACC_IDLE;
    endcase
    // decoded ratios follow the stored codes one cycle later
    st_d.fb_ratio = dec_fb_ratio;
    st_d.fb_ok = dec_fb_ok;
    st_d.fb_g3_ratio = dec_fb_g3_ratio;
    st_d.fb_g3_ok = dec_fb_g3_ok;
    st_d.ref_ratio = dec_ref_ratio;
    st_d.ref_ok = dec_ref_ok;
    // a read sees the words as they stood before this edge; writes leave rdata alone
    if (rd) begin
      st_d.rdata = readback(st_q, i_cfg_addr); // R16
    end
    // each write touches only the bits its word owns
    if (wr && hit(i_cfg_addr, SPC_ADDR_FBDIV)) begin
      st_d.fbdiv = i_cfg_wdata[SPC_FBDIV_LSB +: SPC_FBDIV_W]; // R1 R15
    end
    if (wr && hit(i_cfg_addr, SPC_ADDR_FBDIV_G3)) begin
      st_d.fbdiv_g3 = i_cfg_wdata[SPC_FBDIV_G3_LSB +: SPC_FBDIV_W]; // R2 R15
    end
    if (wr && hit(i_cfg_addr, SPC_ADDR_REFCLK)) begin
      st_d.refdiv = i_cfg_wdata[SPC_REFDIV_LSB +: SPC_REFDIV_W]; // R3
      st_d.src = i_cfg_wdata[SPC_SRC_LSB +: SPC_SRC_W]; // R4
      st_d.alt_en = i_cfg_wdata[SPC_ALT_EN_BIT]; // R5
      st_d.cal_en = i_cfg_wdata[SPC_CAL_EN_BIT]; // R6
      st_d.cal_sel = i_cfg_wdata[SPC_CAL_SEL_BIT]; // R7
    end
    if (wr && hit(i_cfg_addr, SPC_ADDR_CP)) begin
      st_d.cp = i_cfg_wdata[SPC_CP_W-1:0]; // R8 R15
    end
    if (wr && hit(i_cfg_addr, SPC_ADDR_LPF)) begin
      st_d.lpf = i_cfg_wdata; // R9
    end
    if (wr && hit(i_cfg_addr, SPC_ADDR_LPF_G3)) begin
      st_d.lpf_g3 = i_cfg_wdata[SPC_LPF_G3_W-1:0]; // R10 R15
    end
    if (wr && hit(i_cfg_addr, SPC_ADDR_CFG3)) begin
      st_d.cfg3 = i_cfg_wdata; // R11
    end
    if (wr && hit(i_cfg_addr, SPC_ADDR_CFG1_G3)) begin
      st_d.cfg1_g3 = i_cfg_wdata; // R11
    end
    if (wr && hit(i_cfg_addr, SPC_ADDR_CFG2_G3)) begin
      st_d.cfg2_g3 = i_cfg_wdata; // R11
    end
    if (wr && hit(i_cfg_addr, SPC_ADDR_LOCK_G3)) begin
      st_d.lock_g3 = i_cfg_wdata; // R12
    end
    if (wr && hit(i_cfg_addr, SPC_ADDR_RSVD2)) begin
      st_d.rsvd2 = i_cfg_wdata; // R13
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= SPC_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs
  always_comb begin
    // one answer pulse for every access, mapped or not
    case (st_q.acc)
      SPC_ACC_READ: o_cfg_rdy = 1'b1;
      SPC_ACC_WRITE: o_cfg_rdy = 1'b1;
      default: o_cfg_rdy = 1'b0;
    endcase
    o_cfg_rdata = st_q.rdata;
    o_second_loop_feedback_divider = st_q.fbdiv;
    o_second_loop_feedback_divider_gen3 = st_q.fbdiv_g3;
    o_second_loop_refclk_divider = st_q.refdiv;
    o_alt_refclk_source_select = st_q.src;
    o_alt_refclk_path_enable = st_q.alt_en;
    o_calibration_enable = st_q.cal_en;
    o_calibration_select = st_q.cal_sel;
    o_charge_pump_setting = st_q.cp;
    o_loop_filter_setting = st_q.lpf;
    o_loop_filter_setting_gen3 = st_q.lpf_g3;
    o_config_word_three = st_q.cfg3;
    o_config_word_one_gen3 = st_q.cfg1_g3;
    o_config_word_two_gen3 = st_q.cfg2_g3;
    o_lock_config_gen3 = st_q.lock_g3;
    o_reserved_attribute_two = st_q.rsvd2;
    o_fb_ratio = st_q.fb_ratio;
    o_fb_ratio_ok = st_q.fb_ok;
    o_fb_gen3_ratio = st_q.fb_g3_ratio;
    o_fb_gen3_ratio_ok = st_q.fb_g3_ok;
    o_ref_ratio = st_q.ref_ratio;
    o_ref_ratio_ok = st_q.ref_ok;
  end

endmodule : spc_regs

// ===== test/second_pll_config_regs_test.sv
// self-checking bench for the second loop register slice
// assumes the host model spc_cfg_host and the checker bound onto spc_regs
`timescale 1ns/1ps
module second_pll_config_regs_test import spc_pkg::*;;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_cfg_en, i_cfg_we, o_cfg_rdy, o_alt_refclk_path_enable, o_calibration_enable;
  logic o_calibration_select, o_fb_ratio_ok, o_fb_gen3_ratio_ok, o_ref_ratio_ok;
  logic [SPC_AW-1:0] i_cfg_addr;
  logic [SPC_DW-1:0] i_cfg_wdata, o_cfg_rdata, o_loop_filter_setting, o_config_word_three;
  logic [SPC_DW-1:0] o_config_word_one_gen3, o_config_word_two_gen3, o_lock_config_gen3;
  logic [SPC_DW-1:0] o_reserved_attribute_two;
  logic [SPC_FBDIV_W-1:0] o_second_loop_feedback_divider, o_second_loop_feedback_divider_gen3;
  logic [SPC_REFDIV_W-1:0] o_second_loop_refclk_divider, o_ref_ratio;
  logic [SPC_SRC_W-1:0] o_alt_refclk_source_select;
  logic [SPC_CP_W-1:0] o_charge_pump_setting;
  logic [SPC_LPF_G3_W-1:0] o_loop_filter_setting_gen3;
  logic [SPC_RATIO_W-1:0] o_fb_ratio, o_fb_gen3_ratio;
  int n_errors = 0;
  int num_checks = 0;
  int mdl [0:1023];
  int rdv [12] = '{2, 3, 4, 5, 6, 8, 10, 12, 16, 20, 1, 0};
  int rcd [12] = '{0, 1, 2, 3, 5, 6, 7, 13, 14, 15, 16, 4};
  int fbv [4] = '{14, 158, 13, 159};
  always #12.5 i_clk_sys = ~i_clk_sys;
  spc_regs u_dut (.i_clk_sys, .i_rst_n, .i_cfg_en, .i_cfg_we, .i_cfg_addr, .i_cfg_wdata,
    .o_cfg_rdy, .o_cfg_rdata, .o_second_loop_feedback_divider,
    .o_second_loop_feedback_divider_gen3, .o_second_loop_refclk_divider,
    .o_alt_refclk_source_select, .o_alt_refclk_path_enable, .o_calibration_enable,
    .o_calibration_select, .o_charge_pump_setting, .o_loop_filter_setting,
    .o_loop_filter_setting_gen3, .o_config_word_three, .o_config_word_one_gen3,
    .o_config_word_two_gen3, .o_lock_config_gen3, .o_reserved_attribute_two, .o_fb_ratio,
    .o_fb_ratio_ok, .o_fb_gen3_ratio, .o_fb_gen3_ratio_ok, .o_ref_ratio, .o_ref_ratio_ok);
  spc_cfg_host u_host (.i_clk_sys, .i_cfg_rdy(o_cfg_rdy), .i_cfg_rdata(o_cfg_rdata),
    .o_cfg_en(i_cfg_en), .o_cfg_we(i_cfg_we), .o_cfg_addr(i_cfg_addr),
    .o_cfg_wdata(i_cfg_wdata));
  // ==========
  // model and checks
  function automatic int msk(input int a);
    case (a)
      10'h094: return 16'h00FF;
      10'h096, 10'h09C: return 16'h03FF;
      10'h098: return 16'h3FF8;
      10'h09F: return 16'hFF00;
      10'h095, 10'h099, 10'h09A, 10'h09B, 10'h09D, 10'h09E: return 16'hFFFF;
      default: return 0;
    endcase
  endfunction : msk
  task automatic report_and_stop();
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic ok);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t compare %0d differs", $time, num_checks);
    end
  endtask : chk
  task automatic fields();
    int f;
    int g;
    int r;
    f = mdl[10'h094];
    g = mdl[10'h09F] >> 8;
    r = mdl[10'h098];
    chk(o_second_loop_feedback_divider === 8'(f));
    chk(o_fb_ratio === 9'(f + 2) && o_fb_ratio_ok === (f >= 14 && f <= 158));
    chk(o_second_loop_feedback_divider_gen3 === 8'(g));
    chk(o_fb_gen3_ratio === 9'(g + 2) && o_fb_gen3_ratio_ok === (g >= 14 && g <= 158));
    chk(o_second_loop_refclk_divider === 5'(r >> 7));
    chk(o_alt_refclk_source_select === 3'(r >> 3));
    chk(o_alt_refclk_path_enable === r[6]);
    chk(o_calibration_enable === r[12]);
    chk(o_calibration_select === r[13]);
    chk(o_charge_pump_setting === 10'(mdl[10'h096]));
    chk(o_loop_filter_setting === 16'(mdl[10'h099]));
    chk(o_loop_filter_setting_gen3 === 10'(mdl[10'h09C]));
    chk(o_config_word_three === 16'(mdl[10'h095]));
    chk(o_config_word_one_gen3 === 16'(mdl[10'h09A]));
    chk(o_config_word_two_gen3 === 16'(mdl[10'h09B]));
    chk(o_lock_config_gen3 === 16'(mdl[10'h09D]));
    chk(o_reserved_attribute_two === 16'(mdl[10'h09E]));
  endtask : fields
  task automatic acc(input logic we, input int a, input int d);
    logic [SPC_DW-1:0] rdat;
    logic ok;
    u_host.access(we, 10'(a), 16'(d), rdat, ok);
    chk(ok);
    if (ok !== 1'b1)
      report_and_stop();
    else if (we)
      mdl[a] = d & msk(a);
    else
      chk(rdat === 16'(mdl[a]));
  endtask : acc
  task automatic do_reset();
    @(negedge i_clk_sys);
    i_rst_n = 1'b0;
    repeat (6) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    foreach (mdl[i]) mdl[i] = 0;
    mdl[10'h094] = 16'h000E;
    mdl[10'h098] = 16'h0800;
    mdl[10'h09F] = 16'h0E00;
    @(negedge i_clk_sys);
    chk(o_cfg_rdy === 1'b0 && o_cfg_rdata === 16'h0000);
    fields();
  endtask : do_reset
  // ==========
  // scenarios
  initial begin
    int d;
    logic [SPC_DW-1:0] rdat;
    logic ok;
    void'($urandom(32'h7AE2_E020));
    do_reset();
    repeat (3) begin
      for (int a = 10'h093; a <= 10'h0A0; a++) acc(1'b1, a, $urandom_range(16'hFFFF, 0));
      for (int a = 10'h093; a <= 10'h0A0; a++) acc(1'b0, a, 0);
      fields();
    end
    foreach (fbv[i]) begin
      acc(1'b1, 10'h094, fbv[i] | 16'hA500);
      acc(1'b1, 10'h09F, (fbv[i] << 8) | 16'h00FF);
      acc(1'b0, 10'h09F, 0);
      fields();
    end
    foreach (rcd[i]) begin
      d = (mdl[10'h098] & ~16'h0F80) | (rcd[i] << 7);
      acc(1'b1, 10'h098, d);
      @(negedge i_clk_sys);
      chk(o_ref_ratio === 5'(rdv[i]) && o_ref_ratio_ok === (rdv[i] != 0));
    end
    d = $urandom_range(16'hFFFF, 0);
    u_host.write_read(10'h099, 16'(d), rdat, ok);
    mdl[10'h099] = d;
    chk(ok === 1'b1 && rdat === 16'(d));
    do_reset();
    acc(1'b0, 10'h098, 0);
    acc(1'b0, 10'h099, 0);
    report_and_stop();
  end
endmodule : second_pll_config_regs_test

// ===== test/spc_cfg_host.sv
// model of the configuration logic that drives the reconfiguration port
// assumes ready exactly one cycle after a one-cycle enable; drives at falling edges
`timescale 1ns/1ps
module spc_cfg_host
  import spc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_cfg_rdy,
  input wire logic [SPC_DW-1:0] i_cfg_rdata,
  output logic o_cfg_en,
  output logic o_cfg_we,
  output logic [SPC_AW-1:0] o_cfg_addr,
  output logic [SPC_DW-1:0] o_cfg_wdata
);
  initial begin
    o_cfg_en = 1'b0;
    o_cfg_we = 1'b0;
    o_cfg_addr = 10'h000;
    o_cfg_wdata = 16'h0000;
  end
  // ==========
  // port cycles
  // released lines carry the inverse so stale values never pass for requests
  task automatic release_bus();
    o_cfg_en = 1'b0;
    o_cfg_we = ~o_cfg_we;
    o_cfg_addr = ~o_cfg_addr;
    o_cfg_wdata = ~o_cfg_wdata;
  endtask : release_bus
  task automatic access(input logic we, input logic [SPC_AW-1:0] a,
    input logic [SPC_DW-1:0] d, output logic [SPC_DW-1:0] rdat, output logic ok);
    @(negedge i_clk_sys);
    o_cfg_en = 1'b1;
    o_cfg_we = we;
    o_cfg_addr = a;
    o_cfg_wdata = d;
    @(negedge i_clk_sys);
    release_bus();
    ok = (i_cfg_rdy === 1'b1);
    rdat = i_cfg_rdata;
  endtask : access
  // write then read of one word on consecutive edges
  task automatic write_read(input logic [SPC_AW-1:0] a, input logic [SPC_DW-1:0] d,
    output logic [SPC_DW-1:0] rdat, output logic ok);
    @(negedge i_clk_sys);
    o_cfg_en = 1'b1;
    o_cfg_we = 1'b1;
    o_cfg_addr = a;
    o_cfg_wdata = d;
    @(negedge i_clk_sys);
    ok = (i_cfg_rdy === 1'b1);
    o_cfg_we = 1'b0;
    o_cfg_wdata = ~d;
    @(negedge i_clk_sys);
    release_bus();
    ok = ok && (i_cfg_rdy === 1'b1);
    rdat = i_cfg_rdata;
  endtask : write_read
endmodule : spc_cfg_host

// ===== test/spc_regs_props.sv
// assertions on the port behaviour of spc_regs
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
module spc_regs_props
  import spc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_cfg_en,
  input wire logic i_cfg_we,
  input wire logic [SPC_AW-1:0] i_cfg_addr,
  input wire logic [SPC_DW-1:0] i_cfg_wdata,
  input wire logic o_cfg_rdy,
  input wire logic [SPC_DW-1:0] o_cfg_rdata,
  input wire logic [SPC_FBDIV_W-1:0] o_second_loop_feedback_divider,
  input wire logic [SPC_REFDIV_W-1:0] o_second_loop_refclk_divider,
  input wire logic o_calibration_enable,
  input wire logic [SPC_DW-1:0] o_config_word_three,
  input wire logic [SPC_RATIO_W-1:0] o_fb_ratio,
  input wire logic o_fb_ratio_ok
);
  // ==========
  // access decode
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  logic wr;
  logic rd;
  assign wr = i_cfg_en && i_cfg_we;
  assign rd = i_cfg_en && !i_cfg_we;
  // ==========
  // assertions
  AST_RDY_AFTER_EN: assert property (i_cfg_en |=> o_cfg_rdy)
    else $error("ready missing after access");
  AST_RDY_ONLY_EN: assert property (!i_cfg_en |=> !o_cfg_rdy)
    else $error("ready without access");
  AST_FBDIV_WR: assert property (wr && i_cfg_addr == SPC_ADDR_FBDIV |=>
    o_second_loop_feedback_divider == $past(i_cfg_wdata[7:0]))
    else $error("feedback divider not written");
  AST_REFDIV_WR: assert property (wr && i_cfg_addr == SPC_ADDR_REFCLK |=>
    o_second_loop_refclk_divider == $past(i_cfg_wdata[11:7]))
    else $error("reference divider not written");
  AST_CALEN_WR: assert property (wr && i_cfg_addr == SPC_ADDR_REFCLK |=>
    o_calibration_enable == $past(i_cfg_wdata[12]))
    else $error("calibration enable not written");
  AST_FB_RATIO: assert property ($past(i_rst_n) |->
    o_fb_ratio == $past(o_second_loop_feedback_divider) + 9'h002 && o_fb_ratio_ok ==
    ($past(o_second_loop_feedback_divider) inside {[SPC_FB_CODE_MIN:SPC_FB_CODE_MAX]}))
    else $error("decoded feedback ratio wrong");
  AST_RD_UNMAPPED: assert property (rd && i_cfg_addr == 10'h097 |=> o_cfg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_RDATA_HOLD: assert property (!rd |=> $stable(o_cfg_rdata))
    else $error("read data moved without a read");
  AST_CFG3_KEEP: assert property (!(wr && i_cfg_addr == SPC_ADDR_CFG3) |=>
    $stable(o_config_word_three))
    else $error("config word changed without a write");
  COV_WR_FBDIV: cover property (wr && i_cfg_addr == SPC_ADDR_FBDIV);
  COV_B2B: cover property (wr ##1 rd);
  COV_RD_UNMAPPED: cover property (rd && i_cfg_addr == 10'h097);
endmodule : spc_regs_props

bind spc_regs spc_regs_props u_props (.i_clk_sys, .i_rst_n, .i_cfg_en, .i_cfg_we, .i_cfg_addr,
  .i_cfg_wdata, .o_cfg_rdy, .o_cfg_rdata, .o_second_loop_feedback_divider,
  .o_second_loop_refclk_divider, .o_calibration_enable, .o_config_word_three, .o_fb_ratio,
  .o_fb_ratio_ok);
